/* File: src/serial_port_pkg.sv */
package serial_port_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] RECV_CTRL_IDX = 6'h13;
    localparam logic [5:0] XMIT_CTRL_IDX = 6'h15;
    localparam logic [5:0] TX_DATA_IDX = 6'h16;
    localparam logic [5:0] BAUD_IDX = 6'h17;
    localparam logic [5:0] RX_DATA_IDX = 6'h18;

    // transmit status and control bit positions
    localparam int XC_CLK_SRC = 7;
    localparam int XC_NINE = 6;
    localparam int XC_TX_EN = 5;
    localparam int XC_SYNC = 4;
    localparam int XC_EMPTY = 1;
    localparam int XC_NINTH = 0;

    // receive status and control bit positions
    localparam int RC_PORT_EN = 7;
    localparam int RC_NINE = 6;
    localparam int RC_SINGLE = 5;
    localparam int RC_CONT = 4;
    localparam int RC_OVERRUN = 1;
    localparam int RC_NINTH = 0;

    // values after reset
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [3:0] BITCNT_RST = 4'h0;
    localparam logic [8:0] SHIFT_RST = 9'h1ff;

    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic clkSrc;
        logic nineTx;
        logic transmit_enable_bit;
        logic syncMode;
    } tx_cfg_t;

    typedef struct packed {
        logic portEn;
        logic nineRx;
        logic singleRx;
        logic contRx;
    } rx_cfg_t;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } word_t;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* File: src/baud_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen #(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic restart,
    input wire logic [DIV_W-1:0] divisor,
    output logic bitTick,
    output logic midTick
);
    logic [DIV_W:0] cnt_ff;
    logic [DIV_W:0] halfCount;
    logic [DIV_W:0] fullCount;

    // bit period is 2*(divisor+1), so the midpoint is exact
    assign halfCount = {1'b0, divisor};
    assign fullCount = {divisor, 1'b1};
    assign bitTick = !restart && (cnt_ff == fullCount);
    assign midTick = !restart && (cnt_ff == halfCount);

    // restart realigns the phase to a frame start
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (restart || cnt_ff == fullCount) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: src/sync_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // pointers wrap, so depth must be a power of two
    assign inReady = count_ff != FULL_COUNT;
    assign outValid = count_ff != '0;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem_ff[rdPtr_ff];

    // storage needs no reset; pointers define contents
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
            if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
            if (push && !pop) count_ff <= count_ff + 1'b1;
            else if (pop && !push) count_ff <= count_ff - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: src/serial_port_ctrl.sv */
// Function
// RL1: async mode: transmit and receive run independently
// RL2: sync half-duplex as clock master or slave
// RL3: pins serve the port only while enabled
// RL4: pin directions follow enable and clock-source bits
// RL5: clock-source bit selects master or slave clock
// RL6: width bit picks nine or eight bit characters
// RL7: empty flag reads one while shifter idle
// RL8: single receive takes one word, continuous wins
// RL9: transmit enable bit, receive overrides; sync select
`timescale 1ns/1ps
`default_nettype none
module serial_port_ctrl #(
    parameter int FIFO_DEPTH = serial_port_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic receiveDataPinIn,
    output logic receiveDataPinOut,
    output logic receiveDataPinOe,
    input wire logic transmitClockPinIn,
    output logic transmitClockPinOut,
    output logic transmitClockPinOe
);
    serial_port_pkg::tx_cfg_t txCfg_ff;
    serial_port_pkg::rx_cfg_t rxCfg_ff;
    logic ninthTx_ff;
    logic [7:0] baud_ff;
    serial_port_pkg::word_t rxWord_ff;
    logic rxFull_ff;
    logic overrun_ff;
    logic ack_ff;
    logic [31:0] readdata_ff;

    // bus slave
    logic [5:0] regIdx;
    logic busReq;
    logic hitRecv;
    logic hitXmit;
    logic hitTxData;
    logic hitBaud;
    logic hitRxData;
    logic stall;
    logic accept;
    logic wrDone;
    logic rdDone;
    logic lowLane;
    logic fifoInReady;
    logic [7:0] xmitRead;
    logic [7:0] recvRead;
    logic [7:0] readMux;
    logic shiftEmpty;

    // unmapped indices read zero, ignore writes
    assign regIdx = address[7:2];
    assign busReq = read | write;
    assign hitRecv = regIdx == serial_port_pkg::RECV_CTRL_IDX;
    assign hitXmit = regIdx == serial_port_pkg::XMIT_CTRL_IDX;
    assign hitTxData = regIdx == serial_port_pkg::TX_DATA_IDX;
    assign hitBaud = regIdx == serial_port_pkg::BAUD_IDX;
    assign hitRxData = regIdx == serial_port_pkg::RX_DATA_IDX;

    // a full queue stalls a data write
    assign stall = write & hitTxData & ~fifoInReady;
    assign accept = busReq & ack_ff & ~stall;
    assign waitrequest = busReq & ~accept;
    assign wrDone = write & accept;
    assign rdDone = read & accept;
    assign lowLane = byteenable[0];
    assign readdata = readdata_ff;

    // status readback
    assign xmitRead = {txCfg_ff.clkSrc, txCfg_ff.nineTx, txCfg_ff.transmit_enable_bit, txCfg_ff.syncMode,
                       2'b00, shiftEmpty, ninthTx_ff};   // [RL7]
    assign recvRead = {rxCfg_ff.portEn, rxCfg_ff.nineRx, rxCfg_ff.singleRx, rxCfg_ff.contRx,
                       2'b00, overrun_ff, rxWord_ff.ninth};

    always_comb begin
        if (hitXmit) readMux = xmitRead;
        else if (hitRecv) readMux = recvRead;
        else if (hitBaud) readMux = baud_ff;
        else if (hitRxData) readMux = rxWord_ff.data;
        else readMux = 8'h00;
    end

    // one wait state; read data is captured first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            readdata_ff <= 32'h0;
        end else begin
            ack_ff <= busReq & ~accept;
            if (busReq && !ack_ff) readdata_ff <= {24'h0, readMux};
        end
    end

    // pin input synchronisers
    logic [1:0] pinRaw;
    logic [1:0] pinLvl_ff;
    logic [1:0] pinPrev_ff;
    assign pinRaw = {transmitClockPinIn, receiveDataPinIn};

    // three stages; a change counts once the last two agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            logic [serial_port_pkg::SYNC_STAGES-1:0] stage_ff;
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    stage_ff <= '1;
                    pinLvl_ff[gi] <= 1'b1;
                    pinPrev_ff[gi] <= 1'b1;
                end else begin
                    stage_ff <= {stage_ff[1:0], pinRaw[gi]};
                    if (stage_ff[1] == stage_ff[2]) pinLvl_ff[gi] <= stage_ff[2];
                    pinPrev_ff[gi] <= pinLvl_ff[gi];
                end
            end
        end
    endgenerate

    logic dataLvl;
    logic dataFall;
    logic clkRise;
    logic clkFall;
    assign dataLvl = pinLvl_ff[0];
    assign dataFall = pinPrev_ff[0] & ~pinLvl_ff[0];
    assign clkRise = ~pinPrev_ff[1] & pinLvl_ff[1];
    assign clkFall = pinPrev_ff[1] & ~pinLvl_ff[1];

    // mode qualifiers
    logic portOn;
    logic syncOn;
    logic master;
    logic rxSyncEn;
    logic rxAsyncEn;
    logic txActive;
    assign portOn = rxCfg_ff.portEn;                                        // [RL3]
    assign syncOn = txCfg_ff.syncMode;                                      // [RL9]
    assign master = syncOn & txCfg_ff.clkSrc;                               // [RL5]
    assign rxSyncEn = portOn & syncOn & (rxCfg_ff.singleRx | rxCfg_ff.contRx);
    assign rxAsyncEn = portOn & ~syncOn & rxCfg_ff.contRx;                  // [RL1]
    // half duplex: sync receive shuts the transmitter off
    assign txActive = portOn & txCfg_ff.transmit_enable_bit & ~rxSyncEn;                   // [RL9] [RL2]

    // transmit path
    serial_port_pkg::tx_state_t txState_ff;
    serial_port_pkg::tx_state_t nxt_txState;
    logic [8:0] txShift_ff;
    logic [3:0] txCnt_ff;
    logic txLine_ff;
    logic fifoOutValid;
    logic fifoOutReady;
    serial_port_pkg::word_t fifoOutWord;
    serial_port_pkg::word_t fifoInWord;
    logic txRestart;
    logic txBit;
    logic txMid;
    logic txStep;
    logic [3:0] txLast;

    assign fifoInWord = '{ninth: ninthTx_ff, data: writedata[7:0]};
    assign fifoOutReady = (txState_ff == serial_port_pkg::TX_IDLE) & txActive;
    assign txRestart = fifoOutReady & fifoOutValid;
    assign shiftEmpty = txState_ff == serial_port_pkg::TX_IDLE;             // [RL7]
    assign txLast = txCfg_ff.nineTx ? 4'h8 : 4'h7;                          // [RL6]
    // slave shifts on far clock rise, else on own tick
    assign txStep = (syncOn & ~master) ? clkRise : txBit;                   // [RL5]

    sync_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .inValid(wrDone & hitTxData & lowLane),
        .inReady(fifoInReady),
        .inData(fifoInWord),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutWord)
    );

    baud_tick_gen #(
        .DIV_W(8)
    ) u_tx_baud (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(txRestart),
        .divisor(baud_ff),
        .bitTick(txBit),
        .midTick(txMid)
    );

    // disabling transmit drops the word in flight
    always_comb begin
        nxt_txState = txState_ff;
        case (txState_ff)
            serial_port_pkg::TX_IDLE: begin
                if (txRestart) begin
                    nxt_txState = syncOn ? serial_port_pkg::TX_DATA : serial_port_pkg::TX_START;
                end
            end
            serial_port_pkg::TX_START: begin
                if (txBit) nxt_txState = serial_port_pkg::TX_DATA;
            end
            serial_port_pkg::TX_DATA: begin
                if (txStep && txCnt_ff == txLast) begin
                    nxt_txState = syncOn ? serial_port_pkg::TX_IDLE : serial_port_pkg::TX_STOP;
                end
            end
            serial_port_pkg::TX_STOP: begin
                if (txBit) nxt_txState = serial_port_pkg::TX_IDLE;
            end
            default: nxt_txState = serial_port_pkg::TX_IDLE;
        endcase
        if (!txActive) nxt_txState = serial_port_pkg::TX_IDLE;
    end

    // lsb first; ninth bit follows bit 7 in nine-bit mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txState_ff <= serial_port_pkg::TX_IDLE;
            txShift_ff <= serial_port_pkg::SHIFT_RST;
            txCnt_ff <= serial_port_pkg::BITCNT_RST;
        end else begin
            txState_ff <= nxt_txState;
            if (txRestart) begin
                txShift_ff <= fifoOutWord;                                  // [RL6]
                txCnt_ff <= serial_port_pkg::BITCNT_RST;
            end else if (txState_ff == serial_port_pkg::TX_DATA && txStep) begin
                txShift_ff <= {1'b1, txShift_ff[8:1]};
                txCnt_ff <= txCnt_ff + 1'b1;
            end
        end
    end

    // line level: start low, data, stop and idle high
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txLine_ff <= 1'b1;
        end else begin
            case (nxt_txState)
                serial_port_pkg::TX_START: txLine_ff <= 1'b0;
                serial_port_pkg::TX_DATA: txLine_ff <= txRestart ? fifoOutWord.data[0]
                                                                 : txShift_ff[1];
                default: txLine_ff <= 1'b1;
            endcase
            if (txState_ff == serial_port_pkg::TX_DATA && !txStep) txLine_ff <= txShift_ff[0];
        end
    end

    // receive path
    serial_port_pkg::rx_state_t rxState_ff;
    logic [8:0] rxShift_ff;
    logic [3:0] rxCnt_ff;
    logic rxRestart;
    logic rxBit;
    logic rxMid;
    logic rxSample;
    logic [3:0] rxLast;
    logic [8:0] rxFull9;
    logic wordDone;
    serial_port_pkg::word_t rxNew;

    assign rxLast = rxCfg_ff.nineRx ? 4'h8 : 4'h7;
    // start edge aligns async bit clock; sync enable starts it
    assign rxRestart = (rxState_ff == serial_port_pkg::RX_IDLE) &
                       ((rxAsyncEn & dataFall) | rxSyncEn);                 // [RL8]
    // sample on the shift clock's falling edge
    assign rxSample = (syncOn & ~master) ? clkFall : rxMid;                 // [RL5]
    assign rxFull9 = {dataLvl, rxShift_ff[8:1]};
    assign rxNew = rxCfg_ff.nineRx ? rxFull9 : {1'b0, rxFull9[8:1]};
    assign wordDone = (rxState_ff == serial_port_pkg::RX_DATA) & rxSample & syncOn &
                      (rxCnt_ff == rxLast) |
                      (rxState_ff == serial_port_pkg::RX_STOP) & rxMid;

    baud_tick_gen #(
        .DIV_W(8)
    ) u_rx_baud (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(rxRestart),
        .divisor(baud_ff),
        .bitTick(rxBit),
        .midTick(rxMid)
    );

    // losing both enables or the port resets the receiver
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxState_ff <= serial_port_pkg::RX_IDLE;
            rxShift_ff <= serial_port_pkg::SHIFT_RST;
            rxCnt_ff <= serial_port_pkg::BITCNT_RST;
        end else if (!(rxAsyncEn || rxSyncEn)) begin
            rxState_ff <= serial_port_pkg::RX_IDLE;
        end else begin
            case (rxState_ff)
                serial_port_pkg::RX_IDLE: begin
                    rxCnt_ff <= serial_port_pkg::BITCNT_RST;
                    if (rxRestart) begin
                        rxState_ff <= syncOn ? serial_port_pkg::RX_DATA
                                             : serial_port_pkg::RX_START;
                    end
                end
                serial_port_pkg::RX_START: begin
                    // rejects glitches under half a bit
                    if (rxMid) begin
                        rxState_ff <= dataLvl ? serial_port_pkg::RX_IDLE
                                              : serial_port_pkg::RX_DATA;
                    end
                end
                serial_port_pkg::RX_DATA: begin
                    if (rxSample) begin
                        rxShift_ff <= rxFull9;
                        rxCnt_ff <= rxCnt_ff + 1'b1;
                        if (rxCnt_ff == rxLast) begin
                            rxState_ff <= syncOn ? serial_port_pkg::RX_IDLE
                                                 : serial_port_pkg::RX_STOP;
                        end
                    end
                end
                serial_port_pkg::RX_STOP: begin
                    if (rxMid) rxState_ff <= serial_port_pkg::RX_IDLE;
                end
                default: rxState_ff <= serial_port_pkg::RX_IDLE;
            endcase
        end
    end

    // word buffer; async words are whole at the stop bit
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxWord_ff <= '0;
        end else if (wordDone && !rxFull_ff) begin
            rxWord_ff <= syncOn ? rxNew
                                : (rxCfg_ff.nineRx ? rxShift_ff : {1'b0, rxShift_ff[8:1]});
        end
    end

    // shift clock and pins
    logic clkOut_ff;
    logic rxClocking;
    logic txClocking;
    assign rxClocking = master & (rxState_ff == serial_port_pkg::RX_DATA);
    assign txClocking = master & (txState_ff == serial_port_pkg::TX_DATA);

    // master clock: low at mid bit, high at bit end, idles high
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clkOut_ff <= 1'b1;
        end else if (rxClocking) begin
            if (rxMid) clkOut_ff <= 1'b0;
            else if (rxBit) clkOut_ff <= 1'b1;
        end else if (txClocking) begin
            if (txMid) clkOut_ff <= 1'b0;
            else if (txBit) clkOut_ff <= 1'b1;
        end else begin
            clkOut_ff <= 1'b1;
        end
    end

    // clock pin: line in async, shift clock in sync
    assign transmitClockPinOut = syncOn ? clkOut_ff : txLine_ff;
    assign transmitClockPinOe = portOn & (syncOn ? txCfg_ff.clkSrc : txCfg_ff.transmit_enable_bit); // [RL4]
    assign receiveDataPinOut = txLine_ff;
    assign receiveDataPinOe = portOn & syncOn & txActive;                   // [RL4] [RL3]

    // software registers
    logic clrSingle;
    logic setOverrun;
    assign clrSingle = wordDone & syncOn & ~rxCfg_ff.contRx;                // [RL8]
    assign setOverrun = wordDone & rxFull_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txCfg_ff <= '0;
            rxCfg_ff <= '0;
            ninthTx_ff <= 1'b0;
            baud_ff <= serial_port_pkg::BAUD_RST;
        end else begin
            if (clrSingle) rxCfg_ff.singleRx <= 1'b0;
            if (wrDone && lowLane && hitXmit) begin
                txCfg_ff.clkSrc <= writedata[serial_port_pkg::XC_CLK_SRC];  // [RL5]
                txCfg_ff.nineTx <= writedata[serial_port_pkg::XC_NINE];     // [RL6]
                txCfg_ff.transmit_enable_bit <= writedata[serial_port_pkg::XC_TX_EN];      // [RL9]
                txCfg_ff.syncMode <= writedata[serial_port_pkg::XC_SYNC];   // [RL9]
                ninthTx_ff <= writedata[serial_port_pkg::XC_NINTH];
            end
            if (wrDone && lowLane && hitRecv) begin
                rxCfg_ff.portEn <= writedata[serial_port_pkg::RC_PORT_EN];  // [RL3]
                rxCfg_ff.nineRx <= writedata[serial_port_pkg::RC_NINE];
                rxCfg_ff.singleRx <= writedata[serial_port_pkg::RC_SINGLE];
                rxCfg_ff.contRx <= writedata[serial_port_pkg::RC_CONT];
            end
            if (wrDone && lowLane && hitBaud) baud_ff <= writedata[7:0];
        end
    end

    // full and overrun flags: an event beats a clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxFull_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            if (wordDone) rxFull_ff <= 1'b1;
            else if (rdDone && hitRxData) rxFull_ff <= 1'b0;
            if (setOverrun) overrun_ff <= 1'b1;
            else if (wrDone && lowLane && hitRecv && !writedata[serial_port_pkg::RC_CONT]) begin
                overrun_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/serial_port_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_ctrl_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic receiveDataPinOe,
    input wire logic transmitClockPinOut,
    input wire logic transmitClockPinOe
);
    logic [7:0] rc_ff;
    logic [7:0] xc_ff;
    // bus decode and shadowed mode
    wire logic [5:0] idx = address[7:2];
    wire logic xRd = read && !waitrequest && idx == serial_port_pkg::XMIT_CTRL_IDX;
    wire logic isAsync = rc_ff[7] && !xc_ff[4];
    wire logic txLow = isAsync && xc_ff[5] && !transmitClockPinOut;
    // shadow of each control byte as written, all eight bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rc_ff <= 8'h00;
            xc_ff <= 8'h00;
        end else if (write && !waitrequest) begin
            if (idx == serial_port_pkg::RECV_CTRL_IDX) rc_ff <= writedata[7:0];
            if (idx == serial_port_pkg::XMIT_CTRL_IDX) xc_ff <= writedata[7:0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read wait state wrong");
    a_write_wait: assert property ($rose(write) && idx != serial_port_pkg::TX_DATA_IDX
        |-> waitrequest ##1 !waitrequest) else $error("write wait state wrong");
    a_pins_off: assert property (!rc_ff[7] |-> !receiveDataPinOe && !transmitClockPinOe)
        else $error("pin driven while port off");
    a_async_dir: assert property (isAsync |->
        !receiveDataPinOe && transmitClockPinOe == xc_ff[5]) else $error("async pin dir");
    a_sync_clk: assert property (rc_ff[7] && xc_ff[4] |->
        transmitClockPinOe == xc_ff[7]) else $error("sync clock dir");
    a_rx_owns: assert property (rc_ff[7] && xc_ff[4] && rc_ff[4] |-> !receiveDataPinOe)
        else $error("data pin driven in receive");
    a_cfg_read: assert property (xRd |->
        (readdata & 32'hfffffffd) == {24'h0, xc_ff & 8'hf1}) else $error("config readback");
    a_busy_flag: assert property (xRd && $past(txLow) |-> !readdata[1])
        else $error("empty flag during frame");
    cover property (txLow);
    cover property (rc_ff[7] && xc_ff[4] && xc_ff[7]);
    cover property (write && waitrequest ##3 write && waitrequest);
endmodule
bind serial_port_ctrl serial_port_ctrl_asserts asserts_u (.*);
`default_nettype wire

/* File: bench/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int BIT_CYC = 8
) (
    input wire logic ref_clk,
    input wire logic dataOut,
    input wire logic dataOe,
    input wire logic clkOut,
    input wire logic clkOe,
    input wire logic nine,
    output logic dataLine,
    output logic clkLine,
    output logic [9:0] gotWord,
    output logic gotDone
);
    // released pins fall back to the pull-up level
    assign dataLine = dataOe ? dataOut : 1'b1;
    assign clkLine = clkOe ? clkOut : 1'b1;
    // frame catcher: mid-bit samples, lsb first, stop in bit 9
    initial begin
        gotDone = 1'b0;
        forever begin
            @(negedge clkLine);
            gotWord = 10'h000;
            gotDone = 1'b0;
            repeat (BIT_CYC / 2) @(posedge ref_clk);
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT_CYC) @(posedge ref_clk);
                gotWord[i] = clkLine;
            end
            repeat (BIT_CYC) @(posedge ref_clk);
            gotWord[9] = clkLine;
            gotDone = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_serial_port_mode_and_tx_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_mode_and_tx_control;
    localparam logic [5:0] XC = serial_port_pkg::XMIT_CTRL_IDX;
    localparam logic [5:0] RC = serial_port_pkg::RECV_CTRL_IDX;
    localparam logic [5:0] TD = serial_port_pkg::TX_DATA_IDX;
    // {recv ctrl, xmit ctrl, data oe, clock oe}
    localparam logic [17:0] PIN_TAB [6] = '{18'h00080, 18'h20081, 18'h20241,
        18'h20040, 18'h242c1, 18'h28281};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, dOut, dOe, dLine, cOut, cOe, cLine, gotDone;
    logic nineMode = 1'b0;
    logic [9:0] gotWord;
    logic [7:0] rd;
    logic [7:0] w;
    int waits;
    int cyc = 0;
    int failures = 0;
    int checks_done = 0;

    serial_port_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest), .receiveDataPinIn(dLine),
        .receiveDataPinOut(dOut), .receiveDataPinOe(dOe), .transmitClockPinIn(cLine),
        .transmitClockPinOut(cOut), .transmitClockPinOe(cOe));
    serial_peer #(.BIT_CYC(8)) peer_u (.ref_clk(ref_clk), .dataOut(dOut), .dataOe(dOe),
        .clkOut(cOut), .clkOe(cOe), .nine(nineMode), .dataLine(dLine), .clkLine(cLine),
        .gotWord(gotWord), .gotDone(gotDone));

    always #12.5 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end

    // one access, held until waitrequest is low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, wd};
        write <= wr;
        read <= !wr;
        waits = 0;
        do begin
            @(posedge ref_clk);
            waits++;
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_regs();
        bus(1'b0, XC, 8'h00);
        chk("xmitRst", 10'h002, 10'(rd));
        bus(1'b0, 6'h3f, 8'h00);
        chk("unmapped", 10'h000, 10'(rd));
        bus(1'b1, XC, 8'hff);
        bus(1'b0, XC, 8'h00);
        chk("xmitCfg", 10'h0f3, 10'(rd));
    endtask

    task automatic t_pins();
        foreach (PIN_TAB[i]) begin
            bus(1'b1, RC, PIN_TAB[i][17:10]);
            bus(1'b1, XC, PIN_TAB[i][9:2]);
            #1;
            chk("pinDir", 10'(PIN_TAB[i][1:0]), 10'({dOe, cOe}));
        end
        bus(1'b1, RC, 8'h00);
        bus(1'b1, XC, 8'h00);
        repeat (100) @(posedge ref_clk);
    endtask

    // async frame, 8 cycles a bit; busy flag read mid-frame
    task automatic t_frame(input logic nine, input logic [7:0] wd, input logic ninth);
        nineMode = nine;
        w = {1'b0, nine, 5'h10, ninth};
        bus(1'b1, XC, w);
        bus(1'b1, TD, wd);
        bus(1'b0, XC, 8'h00);
        chk("busyFlag", 10'(w), 10'(rd));
        for (int i = 0; i < 300 && gotDone !== 1'b1; i++) @(posedge ref_clk);
        chk("frame", {1'b1, nine & ninth, wd}, gotWord);
    endtask

    // 17 words fill shifter and buffer, the 18th must be held off
    task automatic t_fill();
        int n = 0;
        nineMode = 1'b0;
        bus(1'b1, XC, 8'h20);
        for (int i = 0; i < 18; i++) bus(1'b1, TD, 8'(i));
        chk("fullStall", 10'h001, 10'(waits > 4));
        for (int i = 0; i < 1000 && n < 2; i++) begin
            bus(1'b0, XC, 8'h00);
            n = rd[1] ? n + 1 : 0; // idle lasts one cycle between frames
        end
        chk("drained", 10'h022, 10'(rd));
        chk("lastWord", 10'h211, gotWord);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_pins();
        bus(1'b1, serial_port_pkg::BAUD_IDX, 8'h03);
        bus(1'b1, RC, 8'h80);
        t_frame(1'b0, 8'ha5, 1'b1);
        t_frame(1'b1, 8'h3c, 1'b1);
        t_frame(1'b1, 8'hc3, 1'b0);
        t_fill();
        close_out();
    end
endmodule
`default_nettype wire
